// [design/afe_regs_pkg.sv]
// constants and types shared by the configuration and status register slice
package afe_regs_pkg;
  // register addresses on the serial link
  localparam logic [4:0] ADDR_MAP_FIRST = 5'h00;
  localparam logic [4:0] ADDR_CH_LAST   = 5'h01;
  localparam logic [4:0] ADDR_HOLE_LO   = 5'h02;
  localparam logic [4:0] ADDR_SNAPSHOT  = 5'h08;
  localparam logic [4:0] ADDR_HOLE_MID  = 5'h09;
  localparam logic [4:0] ADDR_SKEW      = 5'h0A;
  localparam logic [4:0] ADDR_AMP       = 5'h0B;
  localparam logic [4:0] ADDR_STATUS    = 5'h0C;
  localparam logic [4:0] ADDR_GRP2_LAST = 5'h0E;
  localparam logic [4:0] ADDR_CFG_LAST  = 5'h12;
  localparam logic [4:0] ADDR_HOLE_HI   = 5'h13;
  localparam logic [4:0] ADDR_LOCK      = 5'h1F;
  // field positions
  localparam int POS_RD_STEP  = 22;
  localparam int POS_WR_STEP  = 21;
  localparam int POS_IDLE     = 20;
  localparam int POS_LINK     = 19;
  localparam int POS_CRC_WIDE = 18;
  localparam int POS_DWIDTH   = 16;
  localparam int POS_COMM_CRC = 15;
  localparam int POS_MAP_INT  = 14;
  localparam int POS_MOD_OUT  = 11;
  localparam int POS_READY    = 0;
  localparam int POS_AMP1     = 3;
  localparam int POS_AMP0     = 0;
  // reset values
  localparam logic [7:0]  SNAPSHOT_RST = 8'h33;
  localparam logic [11:0] SKEW_RST     = 12'h000;
  localparam logic [2:0]  AMP_RST      = 3'h0;
  localparam logic [1:0]  RD_STEP_RST  = 2'h2;
  localparam logic        WR_STEP_RST  = 1'b1;
  localparam logic [1:0]  DWIDTH_RST   = 2'h1;
  localparam logic [1:0]  READY_RST    = 2'h3;
  localparam logic [7:0]  UNLOCK_KEY   = 8'hA5;
  // serial framing
  localparam logic [4:0] CMD_BITS  = 5'h08;
  localparam logic [4:0] WORD_BITS = 5'h18;
  // timing
  localparam int SYS_CLK_MHZ    = 100;
  localparam int READY_PULSE_NS = 80;
  localparam logic [3:0] READY_PULSE_CYCLES =
    4'((READY_PULSE_NS * SYS_CLK_MHZ + 999) / 1000);

  typedef enum logic [1:0] {
    RD_STATIC = 2'b00,
    RD_GROUP  = 2'b01,
    RD_TYPE   = 2'b10,
    RD_MAP    = 2'b11
  } read_step_t;
endpackage

// [design/serial_word_if.sv]
// word-level hand-off between the serial shifter and the register bank
`timescale 1ns/1ns
interface serial_word_if;
  logic        cmdStb;
  logic [4:0]  cmdAddr;
  logic        wordStb;
  logic        wordRead;
  logic [23:0] wordData;
  logic [23:0] rdWord;
  modport shifter (output cmdStb, cmdAddr, wordStb, wordRead, wordData,
                   input rdWord);
  modport regs (input cmdStb, cmdAddr, wordStb, wordRead, wordData,
                output rdWord);
endinterface

// [design/serial_shifter.sv]
// serial link shifter: 8-bit command then 24-bit words, mode 0,0
`timescale 1ns/1ns
module serial_shifter
  import afe_regs_pkg::*;
(
  // clock and reset
  input  wire logic    sys_clk,
  input  wire logic    reset_n,
  // link pins
  input  wire logic    sclk,
  input  wire logic    csN,
  input  wire logic    sdi,
  output logic         sdo,
  output logic         sdoOe,
  // word side
  serial_word_if.shifter lnk
);
  typedef struct packed {
    logic [1:0]  sck;
    logic [1:0]  csq;
    logic [1:0]  sdq;
    logic        sckPrev;
    logic        inCmd;
    logic        isRead;
    logic [4:0]  bitCnt;
    logic [23:0] shIn;
    logic [23:0] shOut;
    logic        sdo;
    logic        sdoOe;
    logic        cmdStb;
    logic [4:0]  cmdAddr;
    logic        wordStb;
    logic        wordRead;
    logic [23:0] wordData;
  } shift_state_t;

  shift_state_t s_q, s_d;
  logic rise, fall;

  always_comb begin
    s_d = s_q;
    s_d.cmdStb = 1'b0;
    s_d.wordStb = 1'b0;
    s_d.sck = {s_q.sck[0], sclk};
    s_d.csq = {s_q.csq[0], csN};
    s_d.sdq = {s_q.sdq[0], sdi};
    s_d.sckPrev = s_q.sck[1];
    rise = s_q.sck[1] & ~s_q.sckPrev;
    fall = ~s_q.sck[1] & s_q.sckPrev;
    if (s_q.csq[1]) begin
      s_d.inCmd = 1'b1;
      s_d.bitCnt = 5'h00;
      s_d.sdoOe = 1'b0;
    end else begin
      if (rise) begin
        s_d.shIn = {s_q.shIn[22:0], s_q.sdq[1]};
        s_d.bitCnt = s_q.bitCnt + 5'h01;
        if (s_q.inCmd && s_q.bitCnt == CMD_BITS - 5'h01) begin
          // top two command bits select a device and are not decoded
          s_d.cmdStb = 1'b1;
          s_d.cmdAddr = s_q.shIn[4:0];
          s_d.isRead = s_q.sdq[1];
          s_d.inCmd = 1'b0;
          s_d.bitCnt = 5'h00;
        end else if (!s_q.inCmd && s_q.bitCnt == WORD_BITS - 5'h01) begin
          s_d.wordStb = 1'b1;
          s_d.wordRead = s_q.isRead;
          s_d.wordData = {s_q.shIn[22:0], s_q.sdq[1]};
          s_d.bitCnt = 5'h00;
        end
      end
      // word is fetched at its first falling edge, after the address moved
      if (fall && !s_q.inCmd && s_q.isRead) begin
        s_d.sdoOe = 1'b1;
        if (s_q.bitCnt == 5'h00) begin
          s_d.sdo = lnk.rdWord[23];
          s_d.shOut = {lnk.rdWord[22:0], 1'b0};
        end else begin
          s_d.sdo = s_q.shOut[23];
          s_d.shOut = {s_q.shOut[22:0], 1'b0};
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      s_q <= '0;
      s_q.sck <= 2'h0;
      s_q.csq <= 2'h3;
      s_q.inCmd <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign sdo = s_q.sdo;
  assign sdoOe = s_q.sdoOe;
  assign lnk.cmdStb = s_q.cmdStb;
  assign lnk.cmdAddr = s_q.cmdAddr;
  assign lnk.wordStb = s_q.wordStb;
  assign lnk.wordRead = s_q.wordRead;
  assign lnk.wordData = s_q.wordData;
endmodule

// [design/afe_config_status_regs.sv]
// configuration and status register slice of a two-channel front end
// Behaviour
// (R1) snapshot refreshes every modulator clock period
// (R2) bits 7-4 channel 1, 3-0 channel 0
// (R3) snapshot resets to zero-volt pattern, upper zero
// (R4) host should not write the snapshot
// (R5) skew write restarts all active converters
// (R6) skew delays channel 0 in modulator periods
// (R7) skew bits 23-12 read zero
// (R8) two 3-bit gain selectors, rest zero
// (R9) gain codes 1..32, reserved act as 1
// (R10) read stepping: map, types, groups, static
// (R11) write stepping: loop writable, or static
// (R12) idle ready pin drives high or floats
// (R13) linked mode: one pulse at lagging converter
// (R14) checksum width select 16 or 32 bits
// (R15) sample width select for all channels
// (R16) ready flags: 0 ready, status read sets
// (R17) host keeps reserved bits 13-12 zero
// (R18) map checksum error holds pin low until unlock
// (R19) fixed bits ignore writes
`timescale 1ns/1ns
module afe_config_status_regs
  import afe_regs_pkg::*;
(
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       reset_n,
  // serial link pins
  input  wire logic       sclk,
  input  wire logic       csN,
  input  wire logic       sdi,
  output logic            sdo,
  output logic            sdoOe,
  // modulator side
  input  wire logic       modClk,
  input  wire logic [7:0] compIn,
  input  wire logic [1:0] chReady,
  // map check
  input  wire logic       mapCrcError,
  input  wire logic [7:0] lockKey,
  // sample-ready pin
  output logic            readyPinOut,
  output logic            readyPinOe,
  // converter control
  output logic            restartAll,
  output logic            startCh1,
  output logic            startCh0,
  output logic [11:0]     skewPeriods,
  output logic [5:0]      gainCh0,
  output logic [5:0]      gainCh1,
  // formatting and options
  output logic            crcWide,
  output logic [1:0]      dataWidth,
  output logic            commCrcEn,
  output logic            mapIntEn,
  output logic            modOutEn
);
  typedef struct packed {
    logic [1:0]  modSync;
    logic        modPrev;
    logic [7:0]  compSync0;
    logic [7:0]  compSync1;
    logic [7:0]  snap;
    logic [11:0] skew;
    logic [2:0]  amp1;
    logic [2:0]  amp0;
    logic [1:0]  rdStep;
    logic        wrStep;
    logic        idleHigh;
    logic        link;
    logic        crcWide;
    logic [1:0]  dWidth;
    logic        commCrc;
    logic        mapInt;
    logic        modOut;
    logic [1:0]  notReady;
    logic [4:0]  addr;
    logic [23:0] rdWord;
    logic        restart;
    logic        start1;
    logic        start0;
    logic [11:0] delayCnt;
    logic        delayRun;
    logic [1:0]  pend;
    logic [3:0]  pulseCnt;
    logic        crcLatch;
    logic        pinOut;
    logic        pinOe;
    logic [5:0]  gain0;
    logic [5:0]  gain1;
  } bank_state_t;

  bank_state_t s_q, s_d;
  logic modEdge, fire, lowNow;
  logic [23:0] w;

  serial_word_if lnk ();

  serial_shifter u_shifter (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .sclk    (sclk),
    .csN     (csN),
    .sdi     (sdi),
    .sdo     (sdo),
    .sdoOe   (sdoOe),
    .lnk     (lnk.shifter)
  );

  function automatic logic [5:0] ampGain(input logic [2:0] code);
    case (code)
      3'h1:    ampGain = 6'h02;
      3'h2:    ampGain = 6'h04;
      3'h3:    ampGain = 6'h08;
      3'h4:    ampGain = 6'h10;
      3'h5:    ampGain = 6'h20;
      default: ampGain = 6'h01; // reserved codes fall back to unity [R9]
    endcase
  endfunction

  // next address inside the loop the stepping mode selects
  function automatic logic [4:0] nextAddr(input logic [4:0] a,
                                          input logic [1:0] mode,
                                          input logic       wr);
    logic [4:0] lo;
    logic [4:0] hi;
    logic [4:0] n;
    lo = a;
    hi = a;
    n = a + 5'h01;
    if (n == ADDR_HOLE_LO) n = ADDR_SNAPSHOT;
    if (n == ADDR_HOLE_MID) n = ADDR_SKEW;
    if (n == ADDR_HOLE_HI) n = ADDR_LOCK;
    if (wr) begin
      lo = ADDR_SNAPSHOT; // [R11]
      hi = ADDR_LOCK;
    end else begin
      case (read_step_t'(mode)) // [R10]
        RD_MAP: begin
          lo = ADDR_MAP_FIRST;
          hi = ADDR_LOCK;
        end
        RD_TYPE: begin
          lo = (a <= ADDR_CH_LAST) ? ADDR_MAP_FIRST : ADDR_SNAPSHOT;
          hi = (a <= ADDR_CH_LAST) ? ADDR_CH_LAST : ADDR_LOCK;
        end
        RD_GROUP: begin
          if (a <= ADDR_CH_LAST) begin
            lo = ADDR_MAP_FIRST;
            hi = ADDR_CH_LAST;
          end else if (a <= ADDR_STATUS) begin
            lo = ADDR_SNAPSHOT;
            hi = ADDR_STATUS;
          end else if (a <= ADDR_GRP2_LAST) begin
            lo = ADDR_STATUS + 5'h01;
            hi = ADDR_GRP2_LAST;
          end else if (a <= ADDR_CFG_LAST) begin
            lo = ADDR_GRP2_LAST + 5'h01;
            hi = ADDR_CFG_LAST;
          end else begin
            lo = ADDR_LOCK;
            hi = ADDR_LOCK;
          end
        end
        default: begin
          lo = a;
          hi = a;
        end
      endcase
    end
    nextAddr = (a == hi) ? lo : n;
  endfunction

  always_comb begin
    s_d = s_q;
    w = lnk.wordData;
    s_d.restart = 1'b0;
    s_d.start1 = 1'b0;
    s_d.start0 = 1'b0;
    s_d.modSync = {s_q.modSync[0], modClk};
    s_d.modPrev = s_q.modSync[1];
    s_d.compSync0 = compIn;
    s_d.compSync1 = s_q.compSync0;
    modEdge = s_q.modSync[1] & ~s_q.modPrev;

    if (lnk.cmdStb) s_d.addr = lnk.cmdAddr;
    if (lnk.wordStb && lnk.wordRead) begin
      if (s_q.addr == ADDR_STATUS) s_d.notReady = READY_RST; // [R16]
      s_d.addr = nextAddr(s_q.addr, s_q.rdStep, 1'b0);
    end else if (lnk.wordStb) begin
      // only implemented fields are stored [R19]
      case (s_q.addr)
        ADDR_SNAPSHOT: s_d.snap = w[7:0];
        ADDR_SKEW: begin
          s_d.skew = w[11:0]; // [R7]
          s_d.restart = 1'b1; // [R5]
          s_d.start1 = 1'b1;
          s_d.start0 = (w[11:0] == 12'h000);
          s_d.delayCnt = w[11:0];
          s_d.delayRun = (w[11:0] != 12'h000);
        end
        ADDR_AMP: begin
          s_d.amp1 = w[POS_AMP1 +: 3]; // [R8]
          s_d.amp0 = w[POS_AMP0 +: 3];
        end
        ADDR_STATUS: begin
          s_d.rdStep = w[POS_RD_STEP +: 2];
          s_d.wrStep = w[POS_WR_STEP];
          s_d.idleHigh = w[POS_IDLE];
          s_d.link = w[POS_LINK];
          s_d.crcWide = w[POS_CRC_WIDE]; // [R14]
          s_d.dWidth = w[POS_DWIDTH +: 2]; // [R15]
          s_d.commCrc = w[POS_COMM_CRC];
          s_d.mapInt = w[POS_MAP_INT];
          s_d.modOut = w[POS_MOD_OUT];
        end
        default: s_d.snap = s_q.snap;
      endcase
      s_d.addr = s_q.wrStep ? nextAddr(s_q.addr, s_q.rdStep, 1'b1)
                            : s_q.addr; // [R11]
    end

    // comparator refresh overrides a host write in the same cycle
    if (modEdge) s_d.snap = s_q.compSync1; // [R1] [R2]

    // channel 1 is the reference; channel 0 starts after the skew [R6]
    // a new skew write owns the counter, so no old count may overwrite it
    if (s_q.delayRun && modEdge && !s_d.restart && !s_q.restart) begin
      s_d.delayCnt = s_q.delayCnt - 12'h001;
      if (s_q.delayCnt == 12'h001) begin
        s_d.start0 = 1'b1;
        s_d.delayRun = 1'b0;
      end
    end

    // a ready event beats a status read in the same cycle [R16]
    s_d.notReady = s_d.notReady & ~chReady;

    s_d.pend = s_q.pend | chReady;
    fire = s_q.link ? (&s_d.pend) : (|chReady); // [R13]
    if (fire || !s_q.link) s_d.pend = 2'h0;
    if (fire) s_d.pulseCnt = READY_PULSE_CYCLES;
    else if (s_q.pulseCnt != 4'h0) s_d.pulseCnt = s_q.pulseCnt - 4'h1;

    // error set beats the unlock clear so no error is missed [R18]
    if (lockKey == UNLOCK_KEY) s_d.crcLatch = 1'b0;
    if (s_q.mapInt && mapCrcError) s_d.crcLatch = 1'b1;

    lowNow = s_d.crcLatch || (s_d.pulseCnt != 4'h0);
    s_d.pinOut = !lowNow;
    s_d.pinOe = lowNow || s_d.idleHigh; // [R12]

    s_d.gain0 = ampGain(s_d.amp0); // [R9]
    s_d.gain1 = ampGain(s_d.amp1);

    // read word for the next fetch; fixed bits read zero [R3] [R7] [R8]
    case (s_d.addr)
      ADDR_SNAPSHOT: s_d.rdWord = {16'h0000, s_d.snap};
      ADDR_SKEW:     s_d.rdWord = {12'h000, s_d.skew};
      ADDR_AMP:      s_d.rdWord = {18'h00000, s_d.amp1, s_d.amp0};
      ADDR_STATUS:   s_d.rdWord = {s_d.rdStep, s_d.wrStep, s_d.idleHigh,
                                   s_d.link, s_d.crcWide, s_d.dWidth,
                                   s_d.commCrc, s_d.mapInt, 2'h0,
                                   s_d.modOut, 9'h000, s_d.notReady};
      default:       s_d.rdWord = 24'h000000;
    endcase
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      s_q <= '0;
      s_q.snap <= SNAPSHOT_RST; // [R3]
      s_q.skew <= SKEW_RST;
      s_q.amp1 <= AMP_RST;
      s_q.amp0 <= AMP_RST;
      s_q.rdStep <= RD_STEP_RST;
      s_q.wrStep <= WR_STEP_RST;
      s_q.dWidth <= DWIDTH_RST;
      s_q.notReady <= READY_RST;
      s_q.pinOut <= 1'b1;
      s_q.gain0 <= 6'h01;
      s_q.gain1 <= 6'h01;
    end else begin
      s_q <= s_d;
    end
  end

  assign lnk.rdWord = s_q.rdWord;
  assign readyPinOut = s_q.pinOut;
  assign readyPinOe = s_q.pinOe;
  assign restartAll = s_q.restart;
  assign startCh1 = s_q.start1;
  assign startCh0 = s_q.start0;
  assign skewPeriods = s_q.skew;
  assign gainCh0 = s_q.gain0;
  assign gainCh1 = s_q.gain1;
  assign crcWide = s_q.crcWide;
  assign dataWidth = s_q.dWidth;
  assign commCrcEn = s_q.commCrc;
  assign mapIntEn = s_q.mapInt;
  assign modOutEn = s_q.modOut;
endmodule

// [bench/host_link_model.sv]
// behavioural host driving the serial link in mode 0,0
`timescale 1ns/1ns
module host_link_model (
  // clock
  input  wire logic sys_clk,
  // link pins
  output logic      sclk,
  output logic      csN,
  output logic      sdi,
  input  wire logic sdo,
  input  wire logic sdoOe
);
  initial begin
    sclk = 1'b0;
    csN  = 1'b1;
    sdi  = 1'b0;
  end
  // read data taken at the closing fall, where the last bit still stands
  task automatic bitx(input logic b, output logic r);
    sdi <= b;
    repeat (4) @(posedge sys_clk);
    sclk <= 1'b1;
    repeat (4) @(posedge sys_clk);
    r = sdoOe ? sdo : ~sdi;
    sclk <= 1'b0;
  endtask
  // clock stands low outside frames
  task automatic frame(input logic [7:0] cmd, input int n,
                       input logic [23:0] wd [4],
                       output logic [23:0] rd [4]);
    logic r;
    csN <= 1'b0;
    repeat (4) @(posedge sys_clk);
    for (int i = 7; i >= 0; i--) bitx(cmd[i], r);
    for (int w = 0; w < n; w++)
      for (int i = 23; i >= 0; i--) bitx(wd[w][i], rd[w][i]);
    repeat (4) @(posedge sys_clk);
    csN <= 1'b1;
    sdi <= ~sdi;
    repeat (8) @(posedge sys_clk);
  endtask
endmodule

// [bench/afe_regs_monitor.sv]
// port checker for the register slice
`timescale 1ns/1ns
module afe_regs_monitor
  import afe_regs_pkg::*;
(
  // clock and reset
  input wire logic        sys_clk,
  input wire logic        reset_n,
  // watched ports
  input wire logic        restartAll,
  input wire logic        startCh1,
  input wire logic        startCh0,
  input wire logic [11:0] skewPeriods,
  input wire logic [5:0]  gainCh0,
  input wire logic [5:0]  gainCh1,
  input wire logic [1:0]  chReady,
  input wire logic        mapCrcError,
  input wire logic [7:0]  lockKey,
  input wire logic        mapIntEn,
  input wire logic        readyPinOut,
  input wire logic        readyPinOe
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  restart_pair_a: assert property (restartAll |-> startCh1)
    else $error("ch1 start missing at restart");
  restart_once_a: assert property (restartAll |=> !restartAll)
    else $error("restart longer than one cycle");
  skew_zero_a: assert property (
    restartAll && skewPeriods == 12'h000 |-> startCh0)
    else $error("ch0 start late with zero skew");
  skew_hold_a: assert property ($changed(skewPeriods) |-> restartAll)
    else $error("skew changed without restart");
  gain_code_a: assert property ($onehot(gainCh0) && gainCh0 <= 6'h20
    && $onehot(gainCh1) && gainCh1 <= 6'h20)
    else $error("gain outside decode set");
  err_low_a: assert property (
    mapIntEn && mapCrcError |=> !readyPinOut && readyPinOe)
    else $error("pin not low on map error");
  err_hold_a: assert property ((mapIntEn && mapCrcError)
    ##1 (lockKey != UNLOCK_KEY) [*3] |=> !readyPinOut)
    else $error("map error released without key");
  pulse_width_a: assert property (
    $fell(readyPinOut) && !mapIntEn |-> (!readyPinOut) [*8])
    else $error("ready pulse too short");
  fall_cause_a: assert property ($fell(readyPinOut) |->
    ($past(chReady) != 2'b00) || ($past(mapIntEn) && $past(mapCrcError)))
    else $error("ready pulse without event");
  pin_driven_a: assert property (!readyPinOut |-> readyPinOe)
    else $error("low level not driven");
endmodule
bind afe_config_status_regs afe_regs_monitor mon (
  .sys_clk(sys_clk), .reset_n(reset_n), .restartAll(restartAll),
  .startCh1(startCh1), .startCh0(startCh0), .skewPeriods(skewPeriods),
  .gainCh0(gainCh0), .gainCh1(gainCh1), .chReady(chReady),
  .mapCrcError(mapCrcError), .lockKey(lockKey), .mapIntEn(mapIntEn),
  .readyPinOut(readyPinOut), .readyPinOe(readyPinOe));

// [bench/tb_top.sv]
// self-checking bench for the register slice
`timescale 1ns/1ns
module tb_top;
  import afe_regs_pkg::*;
  logic        sys_clk, reset_n, sclk, csN, sdi, sdo, sdoOe, modClk;
  logic        mapCrcError, restartAll, startCh1, startCh0, crcWide;
  logic        commCrcEn, mapIntEn, modOutEn, readyPinOut, readyPinOe;
  logic        modRun, modPrev;
  logic [1:0]  modDly;
  logic [7:0]  compIn, lockKey;
  logic [1:0]  chReady, dataWidth;
  logic [11:0] skewPeriods;
  logic [5:0]  gainCh0, gainCh1;
  logic [23:0] wd [4];
  logic [23:0] rd [4];
  logic [4:0]  rsA [4] = '{ADDR_AMP, ADDR_STATUS, ADDR_CH_LAST, ADDR_CH_LAST};
  logic [23:0] rsE [4] = '{24'h3F, 24'hA6, 24'h0, 24'hA6};
  int          n_errors = 0;
  int          cmp_count = 0;
  int          modRises, startAt, restarts, low;

  afe_config_status_regs dut (.sys_clk(sys_clk), .reset_n(reset_n),
    .sclk(sclk), .csN(csN), .sdi(sdi), .sdo(sdo), .sdoOe(sdoOe),
    .modClk(modClk), .compIn(compIn), .chReady(chReady),
    .mapCrcError(mapCrcError), .lockKey(lockKey),
    .readyPinOut(readyPinOut), .readyPinOe(readyPinOe),
    .restartAll(restartAll), .startCh1(startCh1), .startCh0(startCh0),
    .skewPeriods(skewPeriods), .gainCh0(gainCh0), .gainCh1(gainCh1),
    .crcWide(crcWide), .dataWidth(dataWidth), .commCrcEn(commCrcEn),
    .mapIntEn(mapIntEn), .modOutEn(modOutEn));
  host_link_model host (.sys_clk(sys_clk), .sclk(sclk), .csN(csN),
    .sdi(sdi), .sdo(sdo), .sdoOe(sdoOe));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // modulator clock of 20 cycles, held still until the reset read is done
  always begin
    repeat (10) @(posedge sys_clk);
    if (modRun) modClk <= ~modClk;
  end
  // rises counted two flops late, as the pin synchroniser sees them
  always @(posedge sys_clk) begin
    if (restartAll) modRises <= 0;
    else if (modDly[1] && !modPrev) modRises <= modRises + 1;
    if (restartAll) restarts <= restarts + 1;
    if (startCh0) startAt <= modRises;
    modDly <= {modDly[0], modClk};
    modPrev <= modDly[1];
  end

  task automatic test_done;
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [23:0] got, exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [23:0] v);
    wd[0] = v;
    host.frame({2'b00, a, 1'b0}, 1, wd, rd);
  endtask
  task automatic rdn(input logic [4:0] a, input int n);
    host.frame({2'b00, a, 1'b1}, n, wd, rd);
  endtask
  function automatic logic [23:0] stw(input logic [1:0] rs,
    input logic ws, idle, link, input logic [1:0] dw, input logic mi);
    return {rs, ws, idle, link, dw[0], dw, dw[1], mi, 2'b00, dw[0], 11'h0};
  endfunction
  task automatic pulse(input logic [1:0] ch);
    chReady <= ch;
    @(posedge sys_clk);
    chReady <= 2'b00;
    low = 0;
    repeat (30) begin
      @(posedge sys_clk);
      if (readyPinOut === 1'b0 && readyPinOe === 1'b1) low++;
    end
  endtask

  initial begin
    #600000;
    n_errors++;
    test_done();
  end
  initial begin
    reset_n = 1'b0;
    modClk = 1'b0;
    modPrev = 1'b0;
    modDly = 2'b00;
    modRun = 1'b0;
    compIn = 8'h5C;
    chReady = 2'b00;
    mapCrcError = 1'b0;
    lockKey = 8'h00;
    {modRises, startAt, restarts} = '0;
    repeat (8) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rdn(ADDR_SNAPSHOT, 4);
    chk(rd[0], 24'h000033, "snap rst");
    chk(rd[1], 24'h000000, "skew rst");
    chk(rd[2], 24'h000000, "amp rst");
    chk(rd[3], 24'hA10003, "stat rst");
    modRun <= 1'b1;
    // two words in one frame: skew then amp, upper bits ignored
    wd[0] = 24'hFFF003;
    wd[1] = 24'hFFFFEA;
    host.frame({2'b00, ADDR_SKEW, 1'b0}, 2, wd, rd);
    repeat (100) @(posedge sys_clk);
    chk(24'(restarts), 24'd1, "restarts");
    chk(24'(startAt), 24'd3, "ch0 delay");
    chk(24'({gainCh1, gainCh0}), 24'h804, "gains");
    rdn(ADDR_SKEW, 2);
    chk(rd[0], 24'h000003, "skew rb");
    chk(rd[1], 24'h00002A, "amp rb");
    for (int c = 0; c < 8; c++) begin
      wr(ADDR_AMP, {18'h0, 3'(c), 3'(c)});
      chk(24'(gainCh0), c < 6 ? 24'(1) << c : 24'h1, "gain0");
      chk(24'(gainCh1), c < 6 ? 24'(1) << c : 24'h1, "gain1");
    end
    chk(24'(restarts), 24'd1, "no restart");
    compIn <= 8'hA6;
    repeat (100) @(posedge sys_clk);
    rdn(ADDR_SNAPSHOT, 1);
    chk(rd[0], 24'h0000A6, "snapshot");
    for (int m = 0; m < 4; m++) begin
      wr(ADDR_STATUS, stw(2'(m), 1'b1, 1'b0, 1'b0, 2'(m), 1'b0));
      chk(24'({dataWidth, crcWide, commCrcEn, modOutEn, mapIntEn}),
          24'({2'(m), m[0], m[1], m[0], 1'b0}), "fields");
      rdn(rsA[m], 2);
      chk(rd[1], rsE[m], "rd step");
    end
    wr(ADDR_STATUS, stw(2'h2, 1'b0, 1'b0, 1'b0, 2'h1, 1'b0));
    wd[0] = 24'h000001;
    wd[1] = 24'h000002;
    host.frame({2'b00, ADDR_AMP, 1'b0}, 2, wd, rd);
    rdn(ADDR_SKEW, 2);
    chk(rd[0], 24'h000003, "static skew");
    chk(rd[1], 24'h000002, "static amp");
    pulse(2'b01);
    chk(24'(low), 24'd8, "own pulse");
    chk(24'(readyPinOe), 24'h0, "idle float");
    rdn(ADDR_STATUS, 1);
    chk(rd[0], stw(2'h2, 1'b0, 1'b0, 1'b0, 2'h1, 1'b0) | 24'h2, "flag");
    rdn(ADDR_STATUS, 1);
    chk(rd[0], stw(2'h2, 1'b0, 1'b0, 1'b0, 2'h1, 1'b0) | 24'h3, "rearm");
    wr(ADDR_STATUS, stw(2'h2, 1'b1, 1'b1, 1'b1, 2'h1, 1'b0));
    pulse(2'b01);
    chk(24'(low), 24'd0, "link wait");
    chk(24'({readyPinOe, readyPinOut}), 24'h3, "idle high");
    pulse(2'b10);
    chk(24'(low), 24'd8, "link pulse");
    wr(ADDR_STATUS, stw(2'h2, 1'b1, 1'b1, 1'b0, 2'h1, 1'b1));
    mapCrcError <= 1'b1;
    @(posedge sys_clk);
    mapCrcError <= 1'b0;
    repeat (20) @(posedge sys_clk);
    chk(24'(readyPinOut), 24'h0, "err held");
    lockKey <= UNLOCK_KEY;
    repeat (5) @(posedge sys_clk);
    chk(24'(readyPinOut), 24'h1, "err clear");
    lockKey <= 8'h00;
    wr(ADDR_SKEW, 24'h000000);
    repeat (20) @(posedge sys_clk);
    chk(24'(restarts), 24'd2, "zero skew");
    test_done();
  end
endmodule
